// ### design/tlic_cfg.svh
// constants of the two-level interrupt controller: register indices, bit positions,
// reset values, vectors and timing counts. assumes a 100 mhz system clock.
`ifndef TLIC_CFG_SVH
`define TLIC_CFG_SVH

// register indices; byte address on the bus is four times the index
`define TLIC_IDX_TIMER_CONTROL 8'h88
`define TLIC_IDX_TIMER_MODE 8'h89
`define TLIC_IDX_SERIAL_CONTROL 8'h98
`define TLIC_IDX_IRQ_ENABLE 8'hA8
`define TLIC_IDX_IRQ_PRIORITY 8'hB8
`define TLIC_IDX_EXT_ENABLE_ONE 8'hE6
`define TLIC_IDX_EXT_ENABLE_TWO 8'hE7
`define TLIC_IDX_EXT_PRIORITY_ONE 8'hF6
`define TLIC_IDX_EXT_PRIORITY_TWO 8'hF7

// timer control bits
`define TLIC_TC_EXT0_TRIG 0
`define TLIC_TC_EXT0_PEND 1
`define TLIC_TC_EXT1_PEND 3
`define TLIC_TC_T0_OVF 5
`define TLIC_TC_T1_OVF 7
`define TLIC_TC_RESET 8'h0A
// timer mode bits
`define TLIC_TM_EXT0_POL 3
`define TLIC_TM_EXT1_SRC 7
// serial control bits
`define TLIC_SC_RX 0
`define TLIC_SC_TX 1
// enable and priority fields
`define TLIC_IE_GLOBAL 7
`define TLIC_IE_MASK 8'h9F
`define TLIC_IP_MASK 8'h1F
`define TLIC_IP_FIXED 8'h80
`define TLIC_IP_RESET 8'h80
`define TLIC_EX1_BIT 1
`define TLIC_EX2_BIT 0

// vectors in fixed order
`define TLIC_VEC_EXT0 16'h0003
`define TLIC_VEC_T0 16'h000B
`define TLIC_VEC_EXT1 16'h0013
`define TLIC_VEC_T1 16'h001B
`define TLIC_VEC_SERIAL 16'h0023
`define TLIC_VEC_USB 16'h0043
`define TLIC_VEC_VBUS 16'h007B
`define TLIC_VEC_SPARE 16'h0000

// timing
`define TLIC_CALL_CYCLES 3'd4
`define TLIC_LFO_DIV 1
`endif

// ### design/tlic_pkg.sv
// types of the two-level interrupt controller.
// assumes tlic_cfg.svh holds the numeric constants, except NSRC and the extended register masks set in the top module.
package tlic_pkg;
  typedef enum logic [0:0] {TLIC_RUN, TLIC_CALL} tlic_state_t;

  // from the cpu sequencer, same clock
  typedef struct packed {
    logic instr_done;
    logic irq_return;
    logic flash_stall;
  } tlic_cpu_in_t;

  // to the cpu sequencer
  typedef struct packed {
    logic long_call;
    logic call_busy;
    logic [15:0] vector;
    logic level;
  } tlic_cpu_out_t;

  // peripheral events, same clock
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic uart_rx;
    logic uart_tx;
    logic osc_wake;
    logic usb_level;
    logic vbus_level;
  } tlic_periph_t;
endpackage : tlic_pkg

// ### design/tlic_top.sv
// two-level interrupt controller: flags, enables, arbitration, call sequencing, nesting.
// assumes an avalon-mm master on clk and a cpu sequencer that pulses instr_done per
// instruction; pins and the low-frequency oscillator are asynchronous.
`timescale 1ns/1ps
`include "tlic_cfg.svh"

module tlic_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic pin_p0_0,
  input wire logic pin_p0_2,
  input wire logic lfo_clk_in,
  input wire tlic_pkg::tlic_periph_t periph,
  input wire tlic_pkg::tlic_cpu_in_t cpu_in,
  output tlic_pkg::tlic_cpu_out_t cpu_out
);
  localparam int NSRC = 8;

  logic [7:0] timer_control_reg;
  logic [7:0] timer_mode_reg;
  logic [7:0] serial_control_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_priority_reg;
  logic [7:0] extended_enable_reg_one;
  logic [7:0] extended_enable_reg_two;
  logic [7:0] extended_priority_reg_one;
  logic [7:0] extended_priority_reg_two;

  logic served;
  logic bus_req;
  logic bus_wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [31:0] next_readdata;

  logic [1:0] p0_0_sync;
  logic [1:0] p0_2_sync;
  logic [1:0] lfo_sync;
  logic lfo_prev;
  logic lfo_phase;
  logic ext0_level;
  logic ext0_prev;
  logic ext0_event;
  logic ext1_event;

  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] enable;
  logic [NSRC-1:0] prio;
  logic [NSRC-1:0] eligible;
  logic [NSRC-1:0] req_q;
  logic [NSRC-1:0] req_hi;
  logic [NSRC-1:0] req_lo;
  logic [15:0] vec_table [NSRC];

  logic pick_valid;
  logic pick_level;
  logic [2:0] pick_src;
  logic take;
  logic act_hi;
  logic act_lo;
  logic hold_one;
  logic [2:0] call_cnt;
  logic [2:0] src_q;
  tlic_pkg::tlic_state_t state;

  // bus: one wait cycle per access, answer on the second cycle
  assign bus_req = read | write;
  assign bus_wr = write & served;
  assign idx = address[9:2];
  assign wbyte = writedata[7:0];
  assign waitrequest = bus_req & ~served;

  always_ff @(posedge clk) begin
    if (srst) begin
      served <= 1'b0;
    end else begin
      served <= bus_req & ~served;
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (idx)
      `TLIC_IDX_TIMER_CONTROL: next_readdata[7:0] = timer_control_reg;
      `TLIC_IDX_TIMER_MODE: next_readdata[7:0] = timer_mode_reg;
      `TLIC_IDX_SERIAL_CONTROL: next_readdata[7:0] = serial_control_reg;
      `TLIC_IDX_IRQ_ENABLE: next_readdata[7:0] = irq_enable_reg;
      `TLIC_IDX_IRQ_PRIORITY: next_readdata[7:0] = irq_priority_reg;
      `TLIC_IDX_EXT_ENABLE_ONE: next_readdata[7:0] = extended_enable_reg_one;
      `TLIC_IDX_EXT_ENABLE_TWO: next_readdata[7:0] = extended_enable_reg_two;
      `TLIC_IDX_EXT_PRIORITY_ONE: next_readdata[7:0] = extended_priority_reg_one;
      `TLIC_IDX_EXT_PRIORITY_TWO: next_readdata[7:0] = extended_priority_reg_two;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~served) begin
      readdata <= next_readdata;
    end
  end

  // plain configuration registers; unused bits read as fixed values, except in timer mode, which keeps all eight bits as written
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_mode_reg <= 8'h00;
      irq_enable_reg <= 8'h00;
      irq_priority_reg <= `TLIC_IP_RESET;
      extended_enable_reg_one <= 8'h00;
      extended_enable_reg_two <= 8'h00;
      extended_priority_reg_one <= 8'h00;
      extended_priority_reg_two <= 8'h00;
    end else if (bus_wr) begin
      case (idx)
        `TLIC_IDX_TIMER_MODE: timer_mode_reg <= wbyte;
        `TLIC_IDX_IRQ_ENABLE: irq_enable_reg <= wbyte & `TLIC_IE_MASK;
        `TLIC_IDX_IRQ_PRIORITY: irq_priority_reg <= (wbyte & `TLIC_IP_MASK) | `TLIC_IP_FIXED;
        `TLIC_IDX_EXT_ENABLE_ONE: extended_enable_reg_one <= wbyte & 8'h02;
        `TLIC_IDX_EXT_ENABLE_TWO: extended_enable_reg_two <= wbyte & 8'h01;
        `TLIC_IDX_EXT_PRIORITY_ONE: extended_priority_reg_one <= wbyte & 8'h02;
        `TLIC_IDX_EXT_PRIORITY_TWO: extended_priority_reg_two <= wbyte & 8'h01;
        default: ;
      endcase
    end
  end

  // pin and slow oscillator synchronisers, two flops each
  always_ff @(posedge clk) begin
    if (srst) begin
      p0_0_sync <= 2'b00;
      p0_2_sync <= 2'b11;
      lfo_sync <= 2'b00;
    end else begin
      p0_0_sync <= {p0_0_sync[0], pin_p0_0};
      p0_2_sync <= {p0_2_sync[0], pin_p0_2};
      lfo_sync <= {lfo_sync[0], lfo_clk_in};
    end
  end

  // external zero: pin and polarity by mode bit, edge or level by trigger bit
  assign ext0_level = timer_mode_reg[`TLIC_TM_EXT0_POL] ? ~p0_2_sync[1] : p0_0_sync[1];
  assign ext0_event = timer_control_reg[`TLIC_TC_EXT0_TRIG] ?
                      (ext0_level & ~ext0_prev) : ext0_level;

  // external one: every second slow rising edge, or oscillator wake
  assign ext1_event = timer_mode_reg[`TLIC_TM_EXT1_SRC] ?
                      (lfo_sync[1] & ~lfo_prev & lfo_phase) : periph.osc_wake;

  always_ff @(posedge clk) begin
    if (srst) begin
      ext0_prev <= 1'b0;
      lfo_prev <= 1'b0;
      lfo_phase <= 1'b0;
    end else begin
      ext0_prev <= ext0_level;
      lfo_prev <= lfo_sync[1];
      // phase only counts while the slow source is selected, so the edge that
      // the synchroniser sees just after reset cannot skew the divide-by-two
      if (!timer_mode_reg[`TLIC_TM_EXT1_SRC]) begin
        lfo_phase <= 1'b0;
      end else if (lfo_sync[1] & ~lfo_prev) begin
        lfo_phase <= ~lfo_phase;
      end
    end
  end

  // hardware-cleared flags in the timer control register: set beats any clear
  localparam int HWPOS [4] = '{`TLIC_TC_EXT0_PEND, `TLIC_TC_T0_OVF,
                               `TLIC_TC_EXT1_PEND, `TLIC_TC_T1_OVF};
  logic [3:0] hw_set;
  assign hw_set = {periph.t1_ovf, ext1_event, periph.t0_ovf, ext0_event};

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_tc
      if (g == HWPOS[0] || g == HWPOS[1] || g == HWPOS[2] || g == HWPOS[3]) begin : g_flag
        localparam int K = (g == HWPOS[0]) ? 0 : (g == HWPOS[1]) ? 1 :
                           (g == HWPOS[2]) ? 2 : 3;
        logic sw_wr;
        logic vec_clr;
        assign sw_wr = bus_wr && idx == `TLIC_IDX_TIMER_CONTROL;
        assign vec_clr = take && pick_src == 3'(K);
        always_ff @(posedge clk) begin
          if (srst) begin
            timer_control_reg[g] <= 1'(`TLIC_TC_RESET >> g);
          end else if (hw_set[K] | (sw_wr & wbyte[g])) begin
            timer_control_reg[g] <= 1'b1;
          end else if ((sw_wr & ~wbyte[g]) | vec_clr) begin
            timer_control_reg[g] <= 1'b0;
          end
        end
      end else begin : g_plain
        always_ff @(posedge clk) begin
          if (srst) begin
            timer_control_reg[g] <= 1'b0;
          end else if (bus_wr && idx == `TLIC_IDX_TIMER_CONTROL) begin
            timer_control_reg[g] <= wbyte[g];
          end
        end
      end
    end
  endgenerate

  // serial flags: software clears only, events win
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_control_reg <= 8'h00;
    end else begin
      if (bus_wr && idx == `TLIC_IDX_SERIAL_CONTROL) begin
        serial_control_reg <= wbyte;
      end
      if (periph.uart_rx) begin
        serial_control_reg[`TLIC_SC_RX] <= 1'b1;
      end
      if (periph.uart_tx) begin
        serial_control_reg[`TLIC_SC_TX] <= 1'b1;
      end
    end
  end

  // per-source pending, enable and priority, in fixed order; place 7 is a spare
  assign pending = {1'b0, periph.vbus_level, periph.usb_level,
                    serial_control_reg[`TLIC_SC_RX] | serial_control_reg[`TLIC_SC_TX],
                    timer_control_reg[`TLIC_TC_T1_OVF], timer_control_reg[`TLIC_TC_EXT1_PEND],
                    timer_control_reg[`TLIC_TC_T0_OVF], timer_control_reg[`TLIC_TC_EXT0_PEND]};
  assign enable = {1'b0, extended_enable_reg_two[`TLIC_EX2_BIT],
                   extended_enable_reg_one[`TLIC_EX1_BIT], irq_enable_reg[4:0]};
  assign prio = {1'b0, extended_priority_reg_two[`TLIC_EX2_BIT],
                 extended_priority_reg_one[`TLIC_EX1_BIT], irq_priority_reg[4:0]};
  assign vec_table = '{`TLIC_VEC_EXT0, `TLIC_VEC_T0, `TLIC_VEC_EXT1, `TLIC_VEC_T1,
                       `TLIC_VEC_SERIAL, `TLIC_VEC_USB, `TLIC_VEC_VBUS, `TLIC_VEC_SPARE};

  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      assign eligible[g] = pending[g] & enable[g] & irq_enable_reg[`TLIC_IE_GLOBAL];
      assign req_hi[g] = req_q[g] & prio[g];
      assign req_lo[g] = req_q[g] & ~prio[g];
    end
  endgenerate

  // one detect clock; a request caught just before the global clear can still go
  always_ff @(posedge clk) begin
    if (srst) begin
      req_q <= '0;
    end else begin
      req_q <= eligible;
    end
  end

  // level first, then lowest place; preemption gate per level
  always_comb begin
    pick_valid = 1'b0;
    pick_level = 1'b0;
    pick_src = 3'd0;
    if (req_hi != '0 && !act_hi) begin
      pick_valid = 1'b1;
      pick_level = 1'b1;
      for (int i = NSRC - 1; i >= 0; i--) begin
        if (req_hi[i]) begin
          pick_src = 3'(i);
        end
      end
    end else if (req_lo != '0 && !act_hi && !act_lo) begin
      pick_valid = 1'b1;
      for (int i = NSRC - 1; i >= 0; i--) begin
        if (req_lo[i]) begin
          pick_src = 3'(i);
        end
      end
    end
  end

  // call taken only at an instruction end, not after a return, not while stalled
  assign take = pick_valid && state == tlic_pkg::TLIC_RUN && cpu_in.instr_done &&
                !cpu_in.irq_return && !hold_one && !cpu_in.flash_stall;

  // call sequencer: four clocks of long call per vector
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= tlic_pkg::TLIC_RUN;
      call_cnt <= 3'd0;
    end else begin
      case (state)
        tlic_pkg::TLIC_RUN: begin
          if (take) begin
            state <= tlic_pkg::TLIC_CALL;
            call_cnt <= `TLIC_CALL_CYCLES - 3'd1;
          end
        end
        tlic_pkg::TLIC_CALL: begin
          if (call_cnt == 3'd0) begin
            state <= tlic_pkg::TLIC_RUN;
          end else begin
            call_cnt <= call_cnt - 3'd1;
          end
        end
        default: state <= tlic_pkg::TLIC_RUN;
      endcase
    end
  end

  // in-service levels; a return closes the highest open routine
  always_ff @(posedge clk) begin
    if (srst) begin
      act_hi <= 1'b0;
      act_lo <= 1'b0;
    end else if (take) begin
      if (pick_level) begin
        act_hi <= 1'b1;
      end else begin
        act_lo <= 1'b1;
      end
    end else if (cpu_in.instr_done && cpu_in.irq_return) begin
      if (act_hi) begin
        act_hi <= 1'b0;
      end else begin
        act_lo <= 1'b0;
      end
    end
  end

  // one instruction must complete after a return before the next call
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_one <= 1'b0;
    end else if (cpu_in.instr_done) begin
      hold_one <= cpu_in.irq_return;
    end
  end

  // cpu outputs from flops
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_out <= '0;
      src_q <= 3'd0;
    end else begin
      cpu_out.long_call <= take;
      cpu_out.call_busy <= take | (state == tlic_pkg::TLIC_CALL && call_cnt != 3'd0);
      if (take) begin
        cpu_out.vector <= vec_table[pick_src];
        cpu_out.level <= pick_level;
        src_q <= pick_src;
      end
    end
  end

  // checks
  property p_ext_reset;
    @(posedge clk) srst |=> timer_control_reg[`TLIC_TC_EXT0_PEND] &&
                            timer_control_reg[`TLIC_TC_EXT1_PEND];
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("ext flags not set by reset");

  property p_global_mask;
    @(posedge clk) disable iff (srst) !irq_enable_reg[`TLIC_IE_GLOBAL] |=> req_q == '0;
  endproperty
  a_global_mask: assert property (p_global_mask) else $error("request with global off");

  property p_call_len;
    @(posedge clk) disable iff (srst) $rose(cpu_out.long_call) |-> cpu_out.call_busy[*4] ##1
                                      !cpu_out.call_busy;
  endproperty
  a_call_len: assert property (p_call_len) else $error("long call not four clocks");

  property p_stall;
    @(posedge clk) disable iff (srst) cpu_in.flash_stall |=> !cpu_out.long_call;
  endproperty
  a_stall: assert property (p_stall) else $error("call during flash stall");

  property p_after_return;
    @(posedge clk) disable iff (srst) cpu_in.instr_done && cpu_in.irq_return |=>
                                      !cpu_out.long_call ##0 !take;
  endproperty
  a_after_return: assert property (p_after_return) else $error("call right after return");

  property p_no_preempt_high;
    @(posedge clk) disable iff (srst) act_hi |-> !take;
  endproperty
  a_no_preempt_high: assert property (p_no_preempt_high) else $error("high routine preempted");

  property p_vector;
    @(posedge clk) disable iff (srst) cpu_out.long_call && src_q == 3'd2 |->
                                      cpu_out.vector == `TLIC_VEC_EXT1;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector for external one");

  property p_flag_set;
    @(posedge clk) disable iff (srst) periph.t0_ovf |=> timer_control_reg[`TLIC_TC_T0_OVF];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("timer zero flag lost");

  property p_sw_set;
    @(posedge clk) disable iff (srst) bus_wr && idx == `TLIC_IDX_TIMER_CONTROL &&
                                      wbyte[`TLIC_TC_T1_OVF] |=> timer_control_reg[`TLIC_TC_T1_OVF];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set of flag lost");

  c_call: cover property (@(posedge clk) disable iff (srst) cpu_out.long_call);
  c_preempt: cover property (@(posedge clk) disable iff (srst) take && pick_level && act_lo);
  c_reenter: cover property (@(posedge clk) disable iff (srst) hold_one && pick_valid);
endmodule : tlic_top

// ### tb/tlic_cpu_model.sv
// cpu sequencer model: one-cycle instructions, a return on request.
// assumes the controller's cpu ports on the same clock and reset.
`timescale 1ns/1ps
module tlic_cpu_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic stall_req,
  input wire logic ret_req,
  input wire tlic_pkg::tlic_cpu_out_t cpu_out,
  output tlic_pkg::tlic_cpu_in_t cpu_in
);
  logic ret_pend;
  logic go;
  // nothing retires while the call runs or flash stalls the core
  assign go = !stall_req && !cpu_out.call_busy;
  // a requested return waits for the next retiring instruction
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_in <= '0;
      ret_pend <= 1'b0;
    end else begin
      cpu_in.instr_done <= go;
      cpu_in.irq_return <= go && (ret_pend || ret_req);
      cpu_in.flash_stall <= stall_req;
      ret_pend <= (ret_pend || ret_req) && !go;
    end
  end
endmodule : tlic_cpu_model

// ### tb/tb.sv
// testbench of the two-level interrupt controller: bus tasks, event drivers, scenarios.
// assumes tlic_cfg.svh on the include path and the cpu model beside the design.
`timescale 1ns/1ps
`include "tlic_cfg.svh"
module tb;
  localparam logic [7:0] TC = `TLIC_IDX_TIMER_CONTROL;
  localparam logic [7:0] TM = `TLIC_IDX_TIMER_MODE;
  localparam logic [7:0] SC = `TLIC_IDX_SERIAL_CONTROL;
  localparam logic [7:0] IE = `TLIC_IDX_IRQ_ENABLE;
  localparam logic [7:0] IP = `TLIC_IDX_IRQ_PRIORITY;
  localparam logic [7:0] EE1 = `TLIC_IDX_EXT_ENABLE_ONE;
  localparam logic [7:0] EE2 = `TLIC_IDX_EXT_ENABLE_TWO;
  // event bits in the order of the peripheral struct
  localparam logic [6:0] T0 = 7'h40;
  localparam logic [6:0] T1 = 7'h20;
  localparam logic [6:0] RX = 7'h10;
  localparam logic [6:0] WK = 7'h04;
  logic clk;
  logic srst;
  logic read;
  logic write;
  logic [9:0] address;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic pin_p0_0;
  logic pin_p0_2;
  logic lfo_clk_in;
  logic stall_req;
  logic ret_req;
  tlic_pkg::tlic_periph_t periph;
  tlic_pkg::tlic_cpu_in_t cpu_in;
  tlic_pkg::tlic_cpu_out_t cpu_out;
  int err_total;
  int checks_done;

  tlic_top DUT (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pin_p0_0(pin_p0_0), .pin_p0_2(pin_p0_2), .lfo_clk_in(lfo_clk_in),
    .periph(periph), .cpu_in(cpu_in), .cpu_out(cpu_out));
  tlic_cpu_model cpu_model (.clk(clk), .srst(srst), .stall_req(stall_req),
    .ret_req(ret_req), .cpu_out(cpu_out), .cpu_in(cpu_in));

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic fail(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) fail($sformatf("got %h want %h", got, exp));
  endtask : chk

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      fail("bus hang");
      stop_test();
    end
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk({8'h00, q}, {8'h00, exp});
  endtask : rd

  // one-cycle peripheral event
  task automatic ev(input logic [6:0] m);
    @(posedge clk);
    periph <= tlic_pkg::tlic_periph_t'(periph | m);
    @(posedge clk);
    periph <= tlic_pkg::tlic_periph_t'(periph & ~m);
  endtask : ev

  // counts cycles from now until the call pulse
  task automatic wait_call(input logic [15:0] vec, input logic lvl, input int lo,
      input int hi);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_out.long_call !== 1'b1 && n < hi);
    if (cpu_out.long_call !== 1'b1) begin
      fail("no call");
      stop_test();
    end
    if (n < lo) fail("call too early");
    chk(cpu_out.vector, vec);
    chk({15'h0000, cpu_out.level}, {15'h0000, lvl});
  endtask : wait_call

  task automatic no_call(input int n);
    checks_done++;
    repeat (n) begin
      @(negedge clk);
      if (cpu_out.long_call !== 1'b0) fail("call not expected");
    end
  endtask : no_call

  // return instruction once the call sequence is over
  task automatic ret();
    int n;
    n = 0;
    while (cpu_out.call_busy !== 1'b0 && n < 10) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
  endtask : ret

  task automatic s_reset();
    rd(TC, 8'h0A);
    rd(IP, 8'h80);
    rd(IE, 8'h00);
    rd(8'h00, 8'h00);
    wr(TC, 8'h00);
  endtask : s_reset

  task automatic s_mask();
    wr(IE, 8'h02);
    ev(T0);
    no_call(8);
    rd(TC, 8'h20);
    wr(IE, 8'h82);
    wait_call(`TLIC_VEC_T0, 1'b0, 1, 10);
    rd(TC, 8'h00);
    ret();
    ev(T0);
    wait_call(`TLIC_VEC_T0, 1'b0, 3, 3);
    ret();
  endtask : s_mask

  task automatic s_order(input logic [7:0] pri, input logic hi_t1);
    wr(IE, 8'h9A);
    wr(IP, pri);
    ev(T0 | T1);
    wait_call(hi_t1 ? `TLIC_VEC_T1 : `TLIC_VEC_T0, hi_t1, 3, 3);
    ret();
    wait_call(hi_t1 ? `TLIC_VEC_T0 : `TLIC_VEC_T1, 1'b0, 4, 4);
    ret();
  endtask : s_order

  task automatic s_preempt();
    ev(T0);
    wait_call(`TLIC_VEC_T0, 1'b0, 3, 3);
    no_call(6);
    ev(T1);
    wait_call(`TLIC_VEC_T1, 1'b1, 3, 3);
    ev(T0);
    no_call(12);
    ret();
    no_call(12);
    ret();
    wait_call(`TLIC_VEC_T0, 1'b0, 4, 4);
    ret();
  endtask : s_preempt

  task automatic s_serial();
    wr(IP, 8'h00);
    ev(RX);
    wait_call(`TLIC_VEC_SERIAL, 1'b0, 3, 3);
    rd(SC, 8'h01);
    ret();
    wait_call(`TLIC_VEC_SERIAL, 1'b0, 4, 4);
    wr(SC, 8'h00);
    ret();
    no_call(12);
    wr(TC, 8'h80);
    wait_call(`TLIC_VEC_T1, 1'b0, 1, 10);
    ret();
  endtask : s_serial

  task automatic s_ext();
    wr(TM, 8'h08);
    wr(TC, 8'h01);
    wr(IE, 8'h85);
    @(posedge clk);
    pin_p0_2 <= 1'b0;
    wait_call(`TLIC_VEC_EXT0, 1'b0, 2, 12);
    rd(TC, 8'h01);
    ret();
    wr(TM, 8'h80);
    repeat (4) @(posedge clk);
    lfo_clk_in <= 1'b0;
    repeat (4) @(posedge clk);
    lfo_clk_in <= 1'b1;
    no_call(16);
    repeat (4) @(posedge clk);
    lfo_clk_in <= 1'b0;
    repeat (4) @(posedge clk);
    lfo_clk_in <= 1'b1;
    wait_call(`TLIC_VEC_EXT1, 1'b0, 1, 16);
    wr(TC, 8'h01);
    ret();
    wr(TM, 8'h00);
    ev(WK);
    wait_call(`TLIC_VEC_EXT1, 1'b0, 2, 8);
    ret();
  endtask : s_ext

  task automatic s_level(input logic [7:0] idx, input logic [6:0] m, input logic [15:0] v);
    wr(IE, 8'h80);
    wr(idx, 8'h03);
    @(posedge clk);
    periph <= tlic_pkg::tlic_periph_t'(periph | m);
    wait_call(v, 1'b0, 1, 8);
    @(posedge clk);
    periph <= tlic_pkg::tlic_periph_t'(periph & ~m);
    wr(idx, 8'h00);
    ret();
  endtask : s_level

  task automatic s_stall();
    wr(IE, 8'h82);
    @(posedge clk);
    stall_req <= 1'b1;
    ev(T0);
    no_call(20);
    @(posedge clk);
    stall_req <= 1'b0;
    wait_call(`TLIC_VEC_T0, 1'b0, 1, 10);
    ret();
    wr(IE, 8'h02);
    wr(IE, 8'h02);
    ev(T0);
    no_call(8);
  endtask : s_stall

  // main sequence: reset for 12 cycles, then the scenarios
  initial begin
    err_total = 0;
    checks_done = 0;
    srst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h0000_0000;
    pin_p0_0 = 1'b0;
    pin_p0_2 = 1'b1;
    lfo_clk_in = 1'b1;
    stall_req = 1'b0;
    ret_req = 1'b0;
    periph = '0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    s_reset();
    s_mask();
    s_order(8'h00, 1'b0);
    s_order(8'h08, 1'b1);
    s_preempt();
    s_serial();
    s_ext();
    s_level(EE1, 7'h02, `TLIC_VEC_USB);
    s_level(EE2, 7'h01, `TLIC_VEC_VBUS);
    s_stall();
    stop_test();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fail("run too long");
    stop_test();
  end
endmodule : tb
